// ---- bench/ipms_bus_master.sv ----
/* Behavioural two-wire bus master.
   Assumes sda_i is the wired level with a pull-up. */
`timescale 1ns/100ps
`default_nettype none
module ipms_bus_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    // ======================================================================
    // Bus phases, two system clocks each
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic phase();
        repeat (2) @(negedge clk_i);
    endtask
    task automatic start();
        phase();
        sda_o = 1'h1;
        phase();
        scl_o = 1'h1;
        phase();
        sda_o = 1'h0;
        phase();
        scl_o = 1'h0;
    endtask
    task automatic stop();
        phase();
        sda_o = 1'h0;
        phase();
        scl_o = 1'h1;
        phase();
        sda_o = 1'h1;
        phase();
    endtask
    // Data moves mid low phase, never at the clock edge
    task automatic bit_io(input logic b, output logic r);
        phase();
        sda_o = b;
        phase();
        scl_o = 1'h1;
        phase();
        phase();
        r = sda_i;
        scl_o = 1'h0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], nak);
        bit_io(1'h1, nak);
    endtask
    task automatic rbyte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
        bit_io(nak, r);
    endtask
endmodule
`default_nettype wire

// ---- bench/ipms_sva.sv ----
/* Port checker for the paged memory slave.
   Assumes it is bound onto ipms_slave. */
`timescale 1ns/100ps
`default_nettype none
module ipms_sva #(
    parameter int unsigned COMMIT_CYCLES = 20
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       link_clk_i,
    input wire logic       scl_i,
    input wire logic       sda_oe_n_o,
    input wire logic       nv_wr_en_o,
    input wire logic [7:0] nv_wr_addr_o,
    input wire logic       commit_busy_o
);
    // ======================================================================
    // Busy length counter
    logic [31:0] busy_cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !commit_busy_o) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        end
    end
    chk_write_in_busy:
    assert property (@(posedge clk_i) disable iff (rst_i)
        nv_wr_en_o |-> commit_busy_o) else $error("write outside busy");
    chk_page_aligned:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(nv_wr_en_o) |-> nv_wr_addr_o[2:0] == 3'h0)
        else $error("page burst not aligned");
    chk_burst_eight:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(nv_wr_en_o) |-> nv_wr_en_o [*8] ##1 !nv_wr_en_o)
        else $error("page burst not eight bytes");
    chk_addr_step:
    assert property (@(posedge clk_i) disable iff (rst_i)
        nv_wr_en_o && $past(nv_wr_en_o)
        |-> nv_wr_addr_o == $past(nv_wr_addr_o) + 8'h1)
        else $error("burst address not consecutive");
    chk_burst_start:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(commit_busy_o) |-> ##[0:4] nv_wr_en_o)
        else $error("busy without page burst");
    chk_burst_once:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(nv_wr_en_o) |-> $rose(commit_busy_o))
        else $error("second burst in one commit");
    chk_busy_length:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(commit_busy_o) |-> busy_cnt_reg >= COMMIT_CYCLES + 6
        && busy_cnt_reg <= COMMIT_CYCLES + 10)
        else $error("commit time wrong");
    chk_sda_scl_low:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        $changed(sda_oe_n_o) |-> !scl_i)
        else $error("data moved while clock high");
endmodule
bind ipms_slave ipms_sva #(.COMMIT_CYCLES(COMMIT_CYCLES)) i_sva (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
    .sda_oe_n_o(sda_oe_n_o), .nv_wr_en_o(nv_wr_en_o),
    .nv_wr_addr_o(nv_wr_addr_o), .commit_busy_o(commit_busy_o));
`default_nettype wire

// ---- bench/testbench.sv ----
/* Self-checking bench for the paged memory slave.
   Assumes the bus master model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int unsigned CYC = 400;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic link_clk_i = 1'h0;
    logic [2:0] sel = 3'h5;
    logic scl, m_sda, oe_n, sda_o, nv_en, busy;
    logic [7:0] nv_addr, nv_data;
    logic [7:0] seen [256];
    logic [7:0] expm [256];
    int failures = 0;
    int total_checks = 0;
    wire logic sda_w;
    assign sda_w = m_sda & (oe_n | sda_o);
    always #50 clk_i = ~clk_i;
    initial #3 forever #6 link_clk_i = ~link_clk_i;
    // Sampled mid-cycle, where the write pulse has settled
    always @(negedge clk_i) if (nv_en === 1'h1) seen[nv_addr] = nv_data;
    ipms_bus_master i_mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_o(m_sda));
    ipms_slave #(.COMMIT_CYCLES(CYC), .PAGE_BYTES(8)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(oe_n),
        .addr_select_bit0_i(sel[0]), .addr_select_bit1_i(sel[1]),
        .addr_select_bit2_i(sel[2]), .nv_wr_en_o(nv_en),
        .nv_wr_addr_o(nv_addr), .nv_wr_data_o(nv_data),
        .commit_busy_o(busy));
    // ======================================================================
    // Compare and transfer helpers
    task automatic cmp8(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp1(input string n, input logic e, g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask
    // Leaves the bus open: caller stops or restarts
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d);
        logic k;
        i_mst.start();
        i_mst.wbyte({4'ha, sel, 1'h0}, k);
        cmp1("wr hdr ack", 1'h0, k);
        i_mst.wbyte(a, k);
        cmp1("addr ack", 1'h0, k);
        for (int i = 0; i < n; i++) begin
            i_mst.wbyte(d + 8'(i), k);
            cmp1("data ack", 1'h0, k);
            expm[{a[7:3], 3'(a[2:0] + 3'(i))}] = d + 8'(i);
        end
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic k;
        logic [7:0] d;
        i_mst.start();
        i_mst.wbyte({4'ha, sel, 1'h1}, k);
        cmp1("rd hdr ack", 1'h0, k);
        for (int i = 0; i < n; i++) begin
            i_mst.rbyte(i == n - 1, d);
            cmp8("rd data", expm[a + 8'(i)], d);
        end
        i_mst.stop();
    endtask
    // Polls once while busy, then waits out the commit time
    task automatic commit(input logic want, input logic [7:0] pg);
        logic k;
        repeat (20) @(negedge clk_i);
        cmp1("busy", want, busy);
        if (want) begin
            i_mst.start();
            i_mst.wbyte({4'ha, sel, 1'h0}, k);
            i_mst.stop();
            cmp1("poll nack", 1'h1, k);
            for (int i = 0; i < 1000 && busy !== 1'h0; i++) @(negedge clk_i);
            cmp1("busy end", 1'h0, busy);
            for (int i = 0; i < 8; i++)
                cmp8("page", expm[pg + 8'(i)], seen[pg + 8'(i)]);
        end
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_wrap();
        wr(8'h33, 8, 8'h10);
        i_mst.stop();
        commit(1'h1, 8'h30);
        $display("test wrap done");
    endtask
    task automatic t_partial();
        wr(8'h38, 8, 8'h20);
        i_mst.stop();
        commit(1'h1, 8'h38);
        wr(8'h3e, 3, 8'h40);
        i_mst.stop();
        commit(1'h1, 8'h38);
        $display("test partial done");
    endtask
    task automatic t_read();
        wr(8'h36, 0, 8'h00);
        rd(8'h36, 4);
        commit(1'h0, 8'h00);
        rd(8'h3a, 1);
        $display("test read done");
    endtask
    task automatic t_foreign();
        logic k;
        i_mst.start();
        i_mst.wbyte({4'ha, ~sel, 1'h0}, k);
        cmp1("foreign hdr", 1'h1, k);
        i_mst.wbyte(8'h30, k);
        cmp1("foreign byte", 1'h1, k);
        i_mst.stop();
        commit(1'h0, 8'h00);
        rd(8'h3b, 1);
        $display("test foreign done");
    endtask
    task automatic t_shadow();
        wr(8'hf4, 1, 8'h01);
        i_mst.stop();
        commit(1'h1, 8'hf0);
        wr(8'hf5, 1, 8'ha5);
        i_mst.stop();
        commit(1'h0, 8'h00);
        wr(8'hf5, 0, 8'h00);
        rd(8'hf5, 1);
        $display("test shadow done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Two system cycles span many link cycles, so both domains reset
    initial begin
        repeat (2) @(negedge clk_i);
        rst_i = 1'h0;
        repeat (4) @(negedge clk_i);
        t_wrap();
        t_partial();
        t_read();
        t_foreign();
        t_shadow();
        summarize();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        summarize();
    end
endmodule
`default_nettype wire

// ---- design/ipms_map.svh ----
/*
 * Address map, field positions and timing counts of the paged memory slave.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef IPMS_MAP_SVH
`define IPMS_MAP_SVH

// ==========================================================================
// Bus framing
`define IPMS_SLAVE_BASE      4'ha
`define IPMS_BITS_BYTE       4'h8
`define IPMS_BITS_ACK        4'h9

// ==========================================================================
// Memory map
`define IPMS_PAGE_BYTES      8
`define IPMS_NV_USER_LAST    8'h3f
`define IPMS_EE_FIRST        8'hf0
`define IPMS_SHADOW_FIRST    8'hf2
`define IPMS_SHADOW_LAST     8'hf7
`define IPMS_CONFIG_ADDR     8'hf4
`define IPMS_CFG_SEE_BIT     0
`define IPMS_SRAM_FIRST      8'hfa
`define IPMS_SEE_RESET       1'h0

// ==========================================================================
// Timing
`define IPMS_CLK_MHZ         10
`define IPMS_COMMIT_TIME_US  10000
`define IPMS_COMMIT_CYCLES   (`IPMS_COMMIT_TIME_US * `IPMS_CLK_MHZ)

`endif

// ---- design/ipms_pkg.sv ----
/*
 * Types of the paged memory slave.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ipms_pkg;

    // ======================================================================
    // Link engine states
    typedef enum logic [4:0] {
        ipms_idle = 5'h01,
        ipms_hdr  = 5'h02,
        ipms_madr = 5'h04,
        ipms_wdat = 5'h08,
        ipms_rdat = 5'h10
    } ipms_state_t;

endpackage

// ---- design/ipms_slave.sv ----
/*
 * Two-wire serial slave in front of a 256-byte map with EEPROM pages
 * and volatile locations, plus the page commit sequencer.
 * Assumes: scl/sda are pins, sampled on link_clk_i far faster than the
 * bus bit rate; the EEPROM macro outside takes one byte per nv_wr_en_o.
 */
// Functional notes
// - Foreign address: ignore bus until next start
// - Byte after write header loads address counter
// - Up to eight sequential data bytes per write
// - Write counter wraps inside its 8-byte row
// - Rows aligned on multiples of eight
// - Commit after stop; refuse address while busy
// - Commit rewrites whole page, keeping untouched bytes
// - Read starts at current counter value
// - Dummy write sets counter before repeated-start read
// - Master ACK requests another read byte
// - Address is base, select pins, direction bit
// - MSB first; ninth bit low acknowledges
// - Shadow-only bit stops shadowed-byte writes from requesting a commit; a commit of their row still rewrites them
`timescale 1ns/100ps
`default_nettype none
`include "ipms_map.svh"

module ipms_slave #(
    parameter int unsigned COMMIT_CYCLES = `IPMS_COMMIT_CYCLES,
    parameter int unsigned PAGE_BYTES    = `IPMS_PAGE_BYTES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       link_clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic       addr_select_bit0_i,
    input  wire logic       addr_select_bit1_i,
    input  wire logic       addr_select_bit2_i,
    output logic            nv_wr_en_o,
    output logic [7:0]      nv_wr_addr_o,
    output logic [7:0]      nv_wr_data_o,
    output logic            commit_busy_o
);

    localparam int unsigned IDX_W = $clog2(PAGE_BYTES);
    localparam int unsigned CNT_W = $clog2(COMMIT_CYCLES + PAGE_BYTES + 1);
    localparam logic [CNT_W-1:0] JOB_BYTES = CNT_W'(PAGE_BYTES);
    localparam logic [CNT_W-1:0] JOB_LAST  =
        CNT_W'(PAGE_BYTES + COMMIT_CYCLES - 1);

    // ======================================================================
    // Address classes
    function automatic logic is_nv(input logic [7:0] a);
        is_nv = (a <= `IPMS_NV_USER_LAST) ||
                (a >= `IPMS_EE_FIRST && a <= `IPMS_SHADOW_LAST);
    endfunction

    function automatic logic is_shadow(input logic [7:0] a);
        is_shadow = (a >= `IPMS_SHADOW_FIRST) && (a <= `IPMS_SHADOW_LAST);
    endfunction

    function automatic logic is_writable(input logic [7:0] a);
        is_writable = is_nv(a) || (a >= `IPMS_SRAM_FIRST);
    endfunction

    function automatic logic needs_commit(input logic [7:0] a,
                                          input logic       see);
        needs_commit = is_nv(a) && !(see && is_shadow(a));
    endfunction

    // ======================================================================
    // Link domain: synchronisers
    logic [1:0]  lrst_sync_reg;
    logic [1:0]  scl_sync_reg;
    logic [1:0]  sda_sync_reg;
    logic [2:0]  sel_meta_reg;
    logic [2:0]  sel_reg;
    logic [1:0]  ack_sync_reg;
    logic        ack_tgl_reg;
    logic        scl_d_reg;
    logic        sda_d_reg;

    always_ff @(posedge link_clk_i) begin
        lrst_sync_reg <= {lrst_sync_reg[0], rst_i};
        scl_sync_reg  <= {scl_sync_reg[0], scl_i};
        sda_sync_reg  <= {sda_sync_reg[0], sda_i};
        sel_meta_reg  <= {addr_select_bit2_i, addr_select_bit1_i,
                          addr_select_bit0_i};
        sel_reg       <= sel_meta_reg;
        ack_sync_reg  <= {ack_sync_reg[0], ack_tgl_reg};
        scl_d_reg     <= scl_sync_reg[1];
        sda_d_reg     <= sda_sync_reg[1];
    end

    logic lrst;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic link_busy;

    assign lrst      = lrst_sync_reg[1];
    assign scl_q     = scl_sync_reg[1];
    assign sda_q     = sda_sync_reg[1];
    assign scl_rise  = scl_q & ~scl_d_reg;
    assign scl_fall  = ~scl_q & scl_d_reg;
    // Sda moving while scl stays high frames a transfer
    assign bus_start = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
    assign bus_stop  = scl_q & scl_d_reg & ~sda_d_reg & sda_q;

    // ======================================================================
    // Link domain: byte engine
    ipms_pkg::ipms_state_t state_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  ctr_reg;
    logic        rw_reg;
    logic        mack_reg;
    logic        oe_n_reg;
    logic        see_reg;
    logic        dirty_reg;
    logic        req_tgl_reg;
    logic [7-IDX_W:0] page_reg;
    logic [7:0]  mem [0:255];

    logic        hdr_match;
    logic        wr_now;

    assign hdr_match = (shift_reg[7:1] == {`IPMS_SLAVE_BASE, sel_reg})
                       && !link_busy;
    assign wr_now    = scl_fall && (state_reg == ipms_pkg::ipms_wdat) &&
                       (bit_cnt_reg == `IPMS_BITS_BYTE);

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            state_reg   <= ipms_pkg::ipms_idle;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ctr_reg     <= 8'h00;
            rw_reg      <= 1'b0;
            mack_reg    <= 1'b0;
            oe_n_reg    <= 1'b1;
        end else if (bus_start) begin
            // Repeated start lands here too
            state_reg   <= ipms_pkg::ipms_hdr;
            bit_cnt_reg <= 4'h0;
            oe_n_reg    <= 1'b1;
        end else if (bus_stop) begin
            state_reg   <= ipms_pkg::ipms_idle;
            oe_n_reg    <= 1'b1;
        end else if (state_reg == ipms_pkg::ipms_idle) begin
            oe_n_reg    <= 1'b1;
        end else if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (state_reg != ipms_pkg::ipms_rdat) begin
                shift_reg <= {shift_reg[6:0], sda_q};
            end else if (bit_cnt_reg == `IPMS_BITS_BYTE) begin
                mack_reg  <= ~sda_q;
            end
        end else if (scl_fall) begin
            if (bit_cnt_reg == `IPMS_BITS_ACK) begin
                bit_cnt_reg <= 4'h0;
                oe_n_reg    <= 1'b1;
                case (state_reg)
                    ipms_pkg::ipms_hdr: begin
                        if (rw_reg) begin
                            // Read begins where the counter stands
                            state_reg <= ipms_pkg::ipms_rdat;
                            oe_n_reg  <= mem[ctr_reg][7];
                            tx_reg    <= {mem[ctr_reg][6:0], 1'b0};
                            ctr_reg   <= ctr_reg + 8'h01;
                        end else begin
                            state_reg <= ipms_pkg::ipms_madr;
                        end
                    end
                    ipms_pkg::ipms_madr: begin
                        state_reg <= ipms_pkg::ipms_wdat;
                    end
                    ipms_pkg::ipms_wdat: begin
                        state_reg <= ipms_pkg::ipms_wdat;
                    end
                    ipms_pkg::ipms_rdat: begin
                        if (mack_reg) begin
                            oe_n_reg <= mem[ctr_reg][7];
                            tx_reg   <= {mem[ctr_reg][6:0], 1'b0};
                            ctr_reg  <= ctr_reg + 8'h01;
                        end else begin
                            state_reg <= ipms_pkg::ipms_idle;
                        end
                    end
                    default: begin
                        state_reg <= ipms_pkg::ipms_idle;
                    end
                endcase
            end else if (bit_cnt_reg == `IPMS_BITS_BYTE) begin
                case (state_reg)
                    ipms_pkg::ipms_hdr: begin
                        if (hdr_match) begin
                            oe_n_reg <= 1'b0;
                            rw_reg   <= shift_reg[0];
                        end else begin
                            // Not ours or busy: deaf until next start
                            state_reg <= ipms_pkg::ipms_idle;
                        end
                    end
                    ipms_pkg::ipms_madr: begin
                        ctr_reg  <= shift_reg;
                        oe_n_reg <= 1'b0;
                    end
                    ipms_pkg::ipms_wdat: begin
                        // Row-aligned wrap keeps a burst in one page
                        ctr_reg  <= {ctr_reg[7:IDX_W],
                                     ctr_reg[IDX_W-1:0] + 1'b1};
                        oe_n_reg <= 1'b0;
                    end
                    default: begin
                        // Release for the master's acknowledge
                        oe_n_reg <= 1'b1;
                    end
                endcase
            end else if (state_reg == ipms_pkg::ipms_rdat &&
                         bit_cnt_reg != 4'h0) begin
                oe_n_reg <= tx_reg[7];
                tx_reg   <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // ======================================================================
    // Link domain: storage and configuration
    // No reset on the array; contents are undefined until written
    always_ff @(posedge link_clk_i) begin
        if (wr_now && is_writable(ctr_reg)) begin
            mem[ctr_reg] <= shift_reg;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            see_reg <= `IPMS_SEE_RESET;
        end else if (wr_now && ctr_reg == `IPMS_CONFIG_ADDR) begin
            see_reg <= shift_reg[`IPMS_CFG_SEE_BIT];
        end
    end

    // ======================================================================
    // Link domain: commit request
    // Dirty cannot be set while busy: the header was refused then
    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            dirty_reg   <= 1'b0;
            req_tgl_reg <= 1'b0;
            page_reg    <= '0;
        end else if (wr_now && needs_commit(ctr_reg, see_reg)) begin
            dirty_reg   <= 1'b1;
            page_reg    <= ctr_reg[7:IDX_W];
        end else if (bus_stop && dirty_reg) begin
            dirty_reg   <= 1'b0;
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    assign link_busy  = req_tgl_reg ^ ack_sync_reg[1];
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = oe_n_reg;

    // ======================================================================
    // System domain: page commit sequencer
    logic [1:0]       req_sync_reg;
    logic [CNT_W-1:0] job_cnt_reg;
    logic             wr_en_reg;
    logic [7:0]       wr_addr_reg;
    logic [7:0]       wr_data_reg;
    logic             busy_reg;
    logic             job;

    always_ff @(posedge clk_i) begin
        req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
    end

    assign job = req_sync_reg[1] ^ ack_tgl_reg;

    // Page and array stay still while a job runs: the link refuses
    // its address until the acknowledge toggle comes back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_tgl_reg <= 1'b0;
            job_cnt_reg <= '0;
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_en_reg <= 1'b0;
            if (job) begin
                if (job_cnt_reg < JOB_BYTES) begin
                    // Whole page out, untouched bytes from the shadow
                    wr_en_reg   <= 1'b1;
                    wr_addr_reg <= {page_reg, job_cnt_reg[IDX_W-1:0]};
                    wr_data_reg <= mem[{page_reg,
                                        job_cnt_reg[IDX_W-1:0]}];
                    job_cnt_reg <= job_cnt_reg + 1'b1;
                end else if (job_cnt_reg == JOB_LAST) begin
                    ack_tgl_reg <= ~ack_tgl_reg;
                    job_cnt_reg <= '0;
                end else begin
                    job_cnt_reg <= job_cnt_reg + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= job;
        end
    end

    assign nv_wr_en_o    = wr_en_reg;
    assign nv_wr_addr_o  = wr_addr_reg;
    assign nv_wr_data_o  = wr_data_reg;
    assign commit_busy_o = busy_reg;

endmodule

`default_nettype wire
